// ===== fls_event_selector.sv
// Front-end and L2 event selector with its AXI4-Lite control slave.
// Assumes event strobes are synchronous to clock and the counter adds
// cnt_inc every cycle.
//
// What this block does
// R1: Event 19H mask 01H adds each decoded instruction yielding two micro-ops.
// R2: Event 1EH mask 01H counts cycles writing at least one queue entry.
// R3: Event 20H mask 01H counts loops the loop streamer cannot stream.
// R4: 24H/01H counts L2 load hits, demand and prefetch, excluding rejected loads.
// R5: 24H/02H counts L2 load misses, demand and L1 prefetch.
// R6: 24H/03H counts all L2 load requests except rejected load hits.
// R7: 24H/04H counts ownership requests hitting L2, write-combining included.
// R8: 24H/08H counts ownership requests missing L2, demand and prefetch.
// R9: 24H with both ownership bits counts every ownership request.
// R10: 24H/10H counts code fetches hitting L2.
// R11: 24H/20H counts code fetches missing L2.
// R12: 24H/30H counts every code fetch reaching L2.
// R13: 24H/40H counts L2 prefetch hits, code and data.
// R14: 24H/80H counts L2 prefetch misses, code and data.
// R15: 24H with both prefetch bits counts every L2 prefetch.
// R16: 24H/AAH counts every L2 miss of any type.
// R17: 24H/FFH counts every L2 request of any type except rejected load hits.
// R18: 26H bits 01H-08H select demand loads on I, S, E, M lines.
// R19: 26H/0FH counts every demand data request, any line state.
// R20: 26H bits 10H-40H select prefetch data loads on I, S, E lines.
// R21: Prefetch ownership on shared line is a miss; prefetch read a hit.
// R22: Count only on matching event; concurrent sub-events add together.
// R23: Unlisted event and mask combinations never increment.
`timescale 1ns/1ps
module fls_event_selector
  import fls_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // AXI4-Lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [FLS_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  // AXI4-Lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [FLS_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  // AXI4-Lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Raw event strobes from pipeline and L2
  input wire fls_events_s ev,
  // Increment to the programmable counter
  output logic [FLS_INC_W-1:0] cnt_inc
);

  // ----------------------------------------------------------------
  // Selection register
  // ----------------------------------------------------------------
  logic [16:0] sel_q;
  logic [16:0] sel_d;
  wire logic [7:0] sel_evt = sel_q[FLS_SEL_EVT_LSB +: 8];
  wire logic [7:0] sel_um = sel_q[FLS_SEL_UM_LSB +: 8];
  wire logic sel_en = sel_q[FLS_SEL_EN_BIT];

  // ----------------------------------------------------------------
  // Legal combinations
  // ----------------------------------------------------------------
  // Partial masks must not leak counts, so only listed masks pass.
  function automatic logic combo_legal(input logic [7:0] evt, input logic [7:0] um);
    logic ok;
    ok = 1'b0;
    case (evt)
      FLS_EV_DUAL_UOP, FLS_EV_IQ_FILL, FLS_EV_LOOP_FAIL: begin
        ok = (um == FLS_UM_01);
      end
      FLS_EV_L2_REQ: begin
        ok = (um inside {FLS_UM_01, FLS_UM_02, FLS_UM_03, FLS_UM_04, FLS_UM_08,
                         FLS_UM_0C, FLS_UM_10, FLS_UM_20, FLS_UM_30, FLS_UM_40,
                         FLS_UM_80, FLS_UM_C0, FLS_UM_AA, FLS_UM_FF});
      end
      FLS_EV_L2_DATA: begin
        ok = (um inside {FLS_UM_01, FLS_UM_02, FLS_UM_04, FLS_UM_08, FLS_UM_0F,
                         FLS_UM_10, FLS_UM_20, FLS_UM_40});
      end
      default: begin
        ok = 1'b0;
      end
    endcase
    return ok;
  endfunction : combo_legal

  wire logic legal = combo_legal(sel_evt, sel_um); // [R23]

  // ----------------------------------------------------------------
  // Per-port L2 classification
  // ----------------------------------------------------------------
  logic [7:0] req_vec [FLS_L2_PORTS];
  logic [7:0] data_vec [FLS_L2_PORTS];
  logic [FLS_L2_PORTS-1:0] req_sel;
  logic [FLS_L2_PORTS-1:0] data_sel;

  for (genvar p = 0; p < FLS_L2_PORTS; p++) begin : g_port
    fls_l2_req_s r;
    wire logic is_load;
    wire logic is_own;
    wire logic is_code;
    wire logic is_pf;
    wire logic is_pf_data;
    wire logic hit;
    assign r = ev.l2_req[p];
    assign is_load = r.valid && (r.kind == FLS_KIND_LOAD);
    // Write-combining ownership requests arrive as plain ownership requests
    assign is_own = r.valid && (r.kind == FLS_KIND_OWN);
    assign is_code = r.valid && (r.kind == FLS_KIND_CODE);
    assign is_pf = r.valid && (r.kind inside {FLS_KIND_PF_READ, FLS_KIND_PF_OWN,
                                              FLS_KIND_PF_CODE});
    assign is_pf_data = r.valid && (r.kind inside {FLS_KIND_PF_READ, FLS_KIND_PF_OWN});
    // Shared line cannot grant ownership, so a prefetch ownership there misses
    assign hit = (r.line != FLS_LINE_I)
                 && !((r.kind == FLS_KIND_PF_OWN) && (r.line == FLS_LINE_S)); // [R21]
    assign req_vec[p][0] = is_load && hit && !r.rejected; // [R4]
    assign req_vec[p][1] = is_load && !hit; // [R5]
    assign req_vec[p][2] = is_own && hit; // [R7]
    assign req_vec[p][3] = is_own && !hit; // [R8]
    assign req_vec[p][4] = is_code && hit; // [R10]
    assign req_vec[p][5] = is_code && !hit; // [R11]
    assign req_vec[p][6] = is_pf && hit; // [R13]
    assign req_vec[p][7] = is_pf && !hit; // [R14]
    assign data_vec[p][0] = is_load && (r.line == FLS_LINE_I); // [R18]
    assign data_vec[p][1] = is_load && (r.line == FLS_LINE_S); // [R18]
    assign data_vec[p][2] = is_load && (r.line == FLS_LINE_E); // [R18]
    assign data_vec[p][3] = is_load && (r.line == FLS_LINE_M); // [R18]
    assign data_vec[p][4] = is_pf_data && (r.line == FLS_LINE_I); // [R20]
    assign data_vec[p][5] = is_pf_data && (r.line == FLS_LINE_S); // [R20] [R21]
    assign data_vec[p][6] = is_pf_data && (r.line == FLS_LINE_E); // [R20]
    assign data_vec[p][7] = 1'b0;
    // Combined masks OR the one-hot classes: 03H, 0CH, 30H, C0H, AAH, FFH, 0FH
    assign req_sel[p] = |(req_vec[p] & sel_um); // [R6] [R9] [R12] [R15] [R16] [R17]
    assign data_sel[p] = |(data_vec[p] & sel_um); // [R19]
  end : g_port

  // ----------------------------------------------------------------
  // Increment selection
  // ----------------------------------------------------------------
  logic [FLS_INC_W-1:0] req_sum;
  logic [FLS_INC_W-1:0] data_sum;
  logic [FLS_INC_W-1:0] inc_d;
  logic [FLS_INC_W-1:0] inc_q;

  // Each port is one request per cycle; ports add up
  always_comb begin
    req_sum = '0;
    data_sum = '0;
    for (int i = 0; i < FLS_L2_PORTS; i++) begin
      req_sum = req_sum + {{(FLS_INC_W-1){1'b0}}, req_sel[i]}; // [R22]
      data_sum = data_sum + {{(FLS_INC_W-1){1'b0}}, data_sel[i]}; // [R22]
    end
  end

  always_comb begin
    inc_d = '0;
    if (sel_en && legal) begin // [R22] [R23]
      case (sel_evt)
        FLS_EV_DUAL_UOP: begin
          inc_d = {1'b0, ev.dual_microop_decode}; // [R1]
        end
        FLS_EV_IQ_FILL: begin
          inc_d = {{(FLS_INC_W-1){1'b0}}, (ev.iq_entry_written != 3'h0)}; // [R2]
        end
        FLS_EV_LOOP_FAIL: begin
          inc_d = {{(FLS_INC_W-1){1'b0}}, ev.loop_stream_failure}; // [R3]
        end
        FLS_EV_L2_REQ: begin
          inc_d = req_sum;
        end
        FLS_EV_L2_DATA: begin
          inc_d = data_sum;
        end
        default: begin
          inc_d = '0; // [R23]
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      inc_q <= FLS_INC_RST;
    end else begin
      inc_q <= inc_d;
    end
  end

  assign cnt_inc = inc_q;

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  logic aw_hold_q;
  logic w_hold_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic [FLS_ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  wire logic aw_take = s_axi_awvalid && s_axi_awready;
  wire logic w_take = s_axi_wvalid && s_axi_wready;
  wire logic do_write = aw_hold_q && w_hold_q && !bvalid_q;
  wire logic wr_sel = (awaddr_q[FLS_ADDR_W-1:2] == FLS_SEL_OFS[FLS_ADDR_W-1:2]);
  wire logic wr_stat = (awaddr_q[FLS_ADDR_W-1:2] == FLS_STAT_OFS[FLS_ADDR_W-1:2]);

  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready = !w_hold_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // Byte lanes 0 to 2 carry the selection fields
  always_comb begin
    sel_d = sel_q;
    if (do_write && wr_sel) begin
      if (wstrb_q[0]) begin
        sel_d[7:0] = wdata_q[7:0];
      end
      if (wstrb_q[1]) begin
        sel_d[15:8] = wdata_q[15:8];
      end
      if (wstrb_q[2]) begin
        sel_d[16] = wdata_q[16];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      aw_hold_q <= 1'b0;
      awaddr_q <= '0;
    end else if (aw_take) begin
      aw_hold_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (do_write) begin
      aw_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      w_hold_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (w_take) begin
      w_hold_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (do_write) begin
      w_hold_q <= 1'b0;
    end
  end

  // Status is read-only; a write there is accepted and dropped
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      bvalid_q <= 1'b0;
      bresp_q <= FLS_RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q <= (wr_sel || wr_stat) ? FLS_RESP_OKAY : FLS_RESP_DECERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sel_q <= FLS_SEL_RST;
    end else begin
      sel_q <= sel_d;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  wire logic ar_take = s_axi_arvalid && s_axi_arready;
  wire logic rd_sel = (s_axi_araddr[FLS_ADDR_W-1:2] == FLS_SEL_OFS[FLS_ADDR_W-1:2]);
  wire logic rd_stat = (s_axi_araddr[FLS_ADDR_W-1:2] == FLS_STAT_OFS[FLS_ADDR_W-1:2]);
  wire logic [31:0] stat_word = {22'h000000, sel_en, legal, 4'h0, inc_q};
  wire logic [31:0] rd_word = rd_sel ? {15'h0000, sel_q} : (rd_stat ? stat_word : 32'h0);

  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= FLS_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= (rd_sel || rd_stat) ? FLS_RESP_OKAY : FLS_RESP_DECERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule : fls_event_selector

// ===== fls_pkg.sv
// Package for the front-end and L2 event selector: selector codes, register
// map, reset values and the event carrier structs.
// Assumes one core clock; all event strobes arrive synchronous to it.
package fls_pkg;

  // ----------------------------------------------------------------
  // Event numbers
  // ----------------------------------------------------------------
  localparam logic [7:0] FLS_EV_DUAL_UOP = 8'h19;
  localparam logic [7:0] FLS_EV_IQ_FILL = 8'h1e;
  localparam logic [7:0] FLS_EV_LOOP_FAIL = 8'h20;
  localparam logic [7:0] FLS_EV_L2_REQ = 8'h24;
  localparam logic [7:0] FLS_EV_L2_DATA = 8'h26;

  // ----------------------------------------------------------------
  // Unit masks
  // ----------------------------------------------------------------
  localparam logic [7:0] FLS_UM_01 = 8'h01;
  localparam logic [7:0] FLS_UM_02 = 8'h02;
  localparam logic [7:0] FLS_UM_03 = 8'h03;
  localparam logic [7:0] FLS_UM_04 = 8'h04;
  localparam logic [7:0] FLS_UM_08 = 8'h08;
  localparam logic [7:0] FLS_UM_0C = 8'h0c;
  localparam logic [7:0] FLS_UM_0F = 8'h0f;
  localparam logic [7:0] FLS_UM_10 = 8'h10;
  localparam logic [7:0] FLS_UM_20 = 8'h20;
  localparam logic [7:0] FLS_UM_30 = 8'h30;
  localparam logic [7:0] FLS_UM_40 = 8'h40;
  localparam logic [7:0] FLS_UM_80 = 8'h80;
  localparam logic [7:0] FLS_UM_C0 = 8'hc0;
  localparam logic [7:0] FLS_UM_AA = 8'haa;
  localparam logic [7:0] FLS_UM_FF = 8'hff;

  // ----------------------------------------------------------------
  // Register map (byte addresses) and fields
  // ----------------------------------------------------------------
  localparam int FLS_ADDR_W = 8;
  localparam logic [7:0] FLS_SEL_OFS = 8'h00;
  localparam logic [7:0] FLS_STAT_OFS = 8'h04;
  localparam int FLS_SEL_EVT_LSB = 0;
  localparam int FLS_SEL_UM_LSB = 8;
  localparam int FLS_SEL_EN_BIT = 16;
  localparam int FLS_STAT_INC_LSB = 0;
  localparam int FLS_STAT_LEGAL_BIT = 8;
  localparam int FLS_STAT_EN_BIT = 9;
  localparam logic [16:0] FLS_SEL_RST = 17'h00000;
  localparam logic [1:0] FLS_RESP_OKAY = 2'h0;
  localparam logic [1:0] FLS_RESP_DECERR = 2'h3;

  // ----------------------------------------------------------------
  // Event carrier
  // ----------------------------------------------------------------
  localparam int FLS_L2_PORTS = 2;
  localparam int FLS_INC_W = 4;
  localparam logic [FLS_INC_W-1:0] FLS_INC_RST = 4'h0;

  typedef enum logic [2:0] {
    FLS_KIND_LOAD = 3'h0,
    FLS_KIND_OWN = 3'h1,
    FLS_KIND_CODE = 3'h2,
    FLS_KIND_PF_READ = 3'h3,
    FLS_KIND_PF_OWN = 3'h4,
    FLS_KIND_PF_CODE = 3'h5
  } fls_kind_e;

  typedef enum logic [1:0] {
    FLS_LINE_I = 2'h0,
    FLS_LINE_S = 2'h1,
    FLS_LINE_E = 2'h2,
    FLS_LINE_M = 2'h3
  } fls_line_e;

  typedef struct packed {
    logic valid;
    fls_kind_e kind;
    fls_line_e line;
    logic rejected;
  } fls_l2_req_s;

  typedef struct packed {
    logic [2:0] dual_microop_decode;
    logic [2:0] iq_entry_written;
    logic loop_stream_failure;
    fls_l2_req_s [FLS_L2_PORTS-1:0] l2_req;
  } fls_events_s;

endpackage : fls_pkg

// ===== fls_ev_src.sv
// Stand-in for the pipeline and L2 event sources feeding the selector.
// Assumes the bench calls send; each pattern lives exactly one cycle.
`timescale 1ns/1ps
module fls_ev_src
  import fls_pkg::*;
(
  // Clock
  input wire logic clock,
  // Event strobes
  output fls_events_s ev
);
  initial ev = '0;

  // Idle is all zero, so a stale pattern can never be counted twice
  task automatic send(input fls_events_s e);
    @(posedge clock);
    ev <= e;
    @(posedge clock);
    ev <= '0;
  endtask : send
endmodule : fls_ev_src

// ===== fls_event_selector_props.sv
// Checker for the event selector: bus handshakes and increment timing.
// Assumes it is bound to fls_event_selector and sees only its ports.
`timescale 1ns/1ps
module fls_event_selector_props
  import fls_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  // Events and increment
  input wire fls_events_s ev,
  input wire logic [FLS_INC_W-1:0] cnt_inc
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_reset_zero: assert property ($rose(rst_n) |-> cnt_inc == 4'h0)
    else $error("increment not cleared by reset");
  a_idle_no_inc: assert property (ev == '0 |=> cnt_inc == 4'h0)
    else $error("increment without any event");
  a_dual_bound: assert property (ev.l2_req == '0 && ev.iq_entry_written == 3'h0
    && !ev.loop_stream_failure |=> cnt_inc <= {1'b0, $past(ev.dual_microop_decode)})
    else $error("increment above decoded count");
  a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data dropped early");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
endmodule : fls_event_selector_props

bind fls_event_selector fls_event_selector_props chk_i (.*);

// ===== tb.sv
// Self-checking bench for the event selector: registers, then every selection.
// Assumes fls_ev_src drives the event strobes and the checker is bound.
`timescale 1ns/1ps
module tb
  import fls_pkg::*;
;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [FLS_INC_W-1:0] cnt_inc;
  fls_events_s ev;
  logic [31:0] d;
  logic [1:0] r;
  int num_errors = 0;
  int checks = 0;
  int cyc = 0;

  always #4 clock = ~clock;

  fls_ev_src src (.clock(clock), .ev(ev));
  fls_event_selector uut (.clock(clock), .rst_n(rst_n),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .ev(ev), .cnt_inc(cnt_inc));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic print_verdict;
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Address and data offered together; each dropped once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] wd, input logic [3:0] st = 4'hf);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge clock);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= wd;
    s_axi_wstrb <= st;
    s_axi_bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clock);
      if (s_axi_awready && !aw_done) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready && !w_done) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clock); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axw

  task automatic axr(input logic [7:0] a);
    @(posedge clock);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    do @(posedge clock); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clock); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axr

  // Port code: high digit kind, low two bits line, bit 2 rejected, ff idle
  function automatic fls_l2_req_s mk(input logic [7:0] p);
    fls_l2_req_s q;
    q = '0;
    if (p != 8'hff) begin
      q.valid = 1'b1;
      q.kind = fls_kind_e'(p[6:4]);
      q.line = fls_line_e'(p[1:0]);
      q.rejected = p[2];
    end
    return q;
  endfunction : mk

  // fe packs dual-decode count, queue-write count and loop failure
  task automatic run(input logic [7:0] evt, um, p0, p1, input logic [6:0] fe,
                     input logic [3:0] exp);
    fls_events_s e;
    axw(FLS_SEL_OFS, {15'h0, 1'b1, um, evt});
    e = '0;
    e.dual_microop_decode = fe[6:4];
    e.iq_entry_written = fe[3:1];
    e.loop_stream_failure = fe[0];
    e.l2_req[0] = mk(p0);
    e.l2_req[1] = mk(p1);
    src.send(e);
    #1;
    chk({28'h0, cnt_inc}, {28'h0, exp});
  endtask : run

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    axr(FLS_SEL_OFS);
    chk(d, 32'h0);
    axw(FLS_SEL_OFS, 32'h0000_0124);
    axr(FLS_SEL_OFS);
    chk(d, 32'h0000_0124);
    src.send('{default: '0, l2_req: '{mk(8'hff), mk(8'h01)}});
    #1;
    chk({28'h0, cnt_inc}, 32'h0);
    axw(FLS_STAT_OFS, 32'hffff_ffff);
    chk({30'h0, r}, {30'h0, FLS_RESP_OKAY});
    axr(FLS_STAT_OFS);
    chk(d, 32'h0000_0100);
    axw(8'h08, 32'h0000_0001);
    chk({30'h0, r}, {30'h0, FLS_RESP_DECERR});
    axr(8'h08);
    chk({d[29:0], r}, {30'h0, FLS_RESP_DECERR});
    axw(FLS_SEL_OFS, 32'hffff_ffff);
    axr(FLS_SEL_OFS);
    chk(d, 32'h0001_ffff);
    axr(FLS_STAT_OFS);
    chk(d, 32'h0000_0200);
    axw(FLS_SEL_OFS, 32'h0000_0000, 4'h2);
    axr(FLS_SEL_OFS);
    chk(d, 32'h0001_00ff);
    $display("test regs done");
  endtask : t_regs

  task automatic t_table;
    run(8'h19, 8'h01, 8'hff, 8'hff, 7'h70, 4'h7);
    run(8'h1e, 8'h01, 8'hff, 8'hff, 7'h0e, 4'h1);
    run(8'h20, 8'h01, 8'hff, 8'hff, 7'h01, 4'h1);
    run(8'h24, 8'h01, 8'h01, 8'h06, 7'h00, 4'h1);
    run(8'h24, 8'h02, 8'h00, 8'h03, 7'h00, 4'h1);
    run(8'h24, 8'h03, 8'h06, 8'h00, 7'h00, 4'h1);
    run(8'h24, 8'h04, 8'h13, 8'h10, 7'h00, 4'h1);
    run(8'h24, 8'h08, 8'h10, 8'h00, 7'h00, 4'h1);
    run(8'h24, 8'h0c, 8'h10, 8'h11, 7'h00, 4'h2);
    run(8'h24, 8'h10, 8'h22, 8'h20, 7'h00, 4'h1);
    run(8'h24, 8'h20, 8'h20, 8'h20, 7'h00, 4'h2);
    run(8'h24, 8'h30, 8'h21, 8'h20, 7'h00, 4'h2);
    run(8'h24, 8'h40, 8'h31, 8'h41, 7'h00, 4'h1);
    run(8'h24, 8'h80, 8'h41, 8'h50, 7'h00, 4'h2);
    run(8'h24, 8'hc0, 8'h32, 8'h53, 7'h00, 4'h2);
    run(8'h24, 8'haa, 8'h10, 8'h51, 7'h00, 4'h1);
    run(8'h24, 8'hff, 8'h31, 8'h02, 7'h00, 4'h2);
    run(8'h26, 8'h01, 8'h00, 8'h01, 7'h00, 4'h1);
    run(8'h26, 8'h02, 8'h01, 8'h02, 7'h00, 4'h1);
    run(8'h26, 8'h04, 8'h02, 8'h03, 7'h00, 4'h1);
    run(8'h26, 8'h08, 8'h03, 8'h03, 7'h00, 4'h2);
    run(8'h26, 8'h0f, 8'h00, 8'h03, 7'h00, 4'h2);
    run(8'h26, 8'h10, 8'h40, 8'h50, 7'h00, 4'h1);
    run(8'h26, 8'h20, 8'h31, 8'h41, 7'h00, 4'h2);
    run(8'h26, 8'h40, 8'h32, 8'h42, 7'h00, 4'h2);
    run(8'h1e, 8'h01, 8'h01, 8'hff, 7'h50, 4'h0);
    run(8'h24, 8'h05, 8'h01, 8'h00, 7'h00, 4'h0);
    run(8'h26, 8'h80, 8'h03, 8'h33, 7'h00, 4'h0);
    run(8'h19, 8'h02, 8'hff, 8'hff, 7'h50, 4'h0);
    $display("test table done");
  endtask : t_table

  // Mid-run reset must drop the selection and its enable
  task automatic t_reset;
    axw(FLS_SEL_OFS, 32'h0001_0124);
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    axr(FLS_SEL_OFS);
    chk(d, 32'h0);
    src.send('{default: '0, l2_req: '{mk(8'hff), mk(8'h01)}});
    #1;
    chk({28'h0, cnt_inc}, 32'h0);
    $display("test reset done");
  endtask : t_reset

  // Whole run is well under a thousand cycles
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      print_verdict();
    end
  end

  initial begin
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    t_regs();
    t_table();
    t_reset();
    print_verdict();
  end
endmodule : tb
